/* File: src/pfr_pkg.sv */
//==============================================================
// Purpose : constants, types and helpers for the pad function and reset-default block
// Assumes : pad index 0..22 is port A line 0..22, 23..35 is port B line 0..12
// Notes   : function codes 0..7 stand for peripheral selections A..H
//==============================================================
package pfr_pkg;

   //==============================================================
   // pad map
   localparam int           NUM_PADS         = 36;
   localparam int           FUNC_W           = 3;
   localparam int           TCK_PAD          = 0;
   localparam int           TMS_PAD          = 1;
   localparam int           TDO_PAD          = 2;
   localparam int           TDI_PAD          = 3;
   localparam int           RC_PAD           = 20;
   localparam logic [2:0]   FUNC_B           = 3'h1;
   localparam logic [2:0]   FUNC_C           = 3'h2;
   localparam logic [2:0]   FUNC_D           = 3'h3;
   localparam logic [2:0]   FUNC_F           = 3'h5;
   localparam logic [35:0]  TWI_PAD_MASK     = 36'h0_1822_00A0;
   localparam logic [35:0]  ADC_PAD_MASK     = 36'h0_E00D_C000;
   localparam logic [35:0]  PULL_RESET_MASK  = 36'h0_0000_0001;

   //==============================================================
   // types
   typedef struct packed {
      logic              gpio_en;  // 1: plain gpio, 0: peripheral mux
      logic [FUNC_W-1:0] func;
      logic              oe;
      logic              out;
      logic              pull;
   } pfr_pad_cfg_t;

   typedef struct packed {
      logic [2:0]                      rst_pin_sync;
      logic                            rst_pin_stable;
      logic [2:0]                      tck_sync;
      logic                            tck_stable;
      logic [2:0]                      rc_sync;
      logic                            rc_stable;
      logic                            in_reset;
      logic                            debug_en;
      logic                            rc_en;
      pfr_pad_cfg_t [NUM_PADS-1:0]     cfg;
      logic [NUM_PADS-1:0]             od;
      logic [NUM_PADS-1:0]             pad_out;
      logic [NUM_PADS-1:0]             pad_oe_n;
      logic [NUM_PADS-1:0]             pad_pull;
      logic [NUM_PADS-1:0]             adc_en;
   } pfr_state_t;

   //==============================================================
   // helpers
   // two-wire selections per capable pad, bit n = function code n
   function automatic logic [7:0] twi_func_mask(input int idx);
      unique case (idx)
         5:       twi_func_mask = 8'h42;
         7:       twi_func_mask = 8'h0C;
         17:      twi_func_mask = 8'h08;
         21:      twi_func_mask = 8'h02;
         27:      twi_func_mask = 8'h48;
         28:      twi_func_mask = 8'h08;
         default: twi_func_mask = 8'h00;
      endcase
   endfunction : twi_func_mask

   function automatic pfr_pad_cfg_t pad_reset_cfg(input int idx);
      pfr_pad_cfg_t c;
      c         = '0;
      c.gpio_en = 1'b1;
      c.pull    = PULL_RESET_MASK[idx];
      unique case (idx)
         5, 21:       begin c.gpio_en = 1'b0; c.func = FUNC_B; end
         7:           begin c.gpio_en = 1'b0; c.func = FUNC_C; end
         17, 27, 28:  begin c.gpio_en = 1'b0; c.func = FUNC_D; end
         RC_PAD:      begin c.gpio_en = 1'b0; c.func = FUNC_F; end
         default:     c.gpio_en = 1'b1;
      endcase
      return c;
   endfunction : pad_reset_cfg

   // change counts once second and third stages agree
   function automatic logic sync_stable(input logic s2, input logic s3, input logic prev);
      return (s2 == s3) ? s3 : prev;
   endfunction : sync_stable

endpackage : pfr_pkg

/* File: src/pfr_pad_function.sv */
//==============================================================
// Purpose : pad function selection, pull control and reset defaults for 36 pads
// Assumes : reset_i is the power-on reset; the external reset pin arrives raw
// Notes   : rc clock enable is set only by reset_i, never by the reset pin
//
// Function
// RULE1: debug port on if tck low at release
// RULE2: debug on: pulls on tck tms tdi, tdo driven
// RULE3: tck pull-up always on during reset
// RULE4: debug off: four pads back to normal mux
// RULE5: software uses tck-shared gpio only as output
// RULE6: board leaves reset pin undriven during debug
// RULE7: two-wire selection drives pads open-drain only
// RULE8: reset selects two-wire function on six pads
// RULE9: each line has its own pull-up enable
// RULE10: reset: inputs, no pull, except tck pad
// RULE11: reset selects function F on rc pad
// RULE12: slow rc clock out even during reset
// RULE13: leaving F, gpio or force zero stops clock
// RULE14: slow clock output never re-enabled once stopped; code sets it again on reset_i
// RULE15: software stops rc out before crystal out
// RULE16: no analog input while pad driven
// RULE17: precedence mux, trace, debug_data_out_pad, debug port, osc
// RULE18: enabled debug port owns its pads
// RULE19: debug_data_out_pad only with link on and two-pin
// RULE20: debug enable held until next reset
//==============================================================
`timescale 1ns/1ps

module pfr_pad_function
   import pfr_pkg::*;
(
   // clock and reset
   input  wire logic                clk_sys_i,
   input  wire logic                reset_i,
   input  wire logic                ext_reset_pin_n_i,
   // pad configuration from software
   input  wire logic [NUM_PADS-1:0] cfg_wr_i,
   input  wire pfr_pad_cfg_t        cfg_data_i,
   input  wire logic                force_slow_clock_out_bit_i,
   // peripheral, trace and debug sources
   input  wire logic [NUM_PADS-1:0] periph_out_i,
   input  wire logic [NUM_PADS-1:0] periph_oe_i,
   input  wire logic [NUM_PADS-1:0] trace_out_i,
   input  wire logic [NUM_PADS-1:0] trace_oe_i,
   input  wire logic                jtag_tdo_i,
   input  wire logic                sp_link_en_i,
   input  wire logic                sp_two_pin_mode_i,
   input  wire logic                debug_data_out_pad_i,
   input  wire logic                alt_crystal_out_pin_en_i,
   input  wire logic                slow_rc_oscillator_i,
   input  wire logic [NUM_PADS-1:0] adc_req_i,
   // pads
   input  wire logic                port_a_line_zero_in_i,
   output logic [NUM_PADS-1:0]      pad_out_o,
   output logic [NUM_PADS-1:0]      pad_oe_n_o,
   output logic [NUM_PADS-1:0]      pad_pull_o,
   // status
   output logic [NUM_PADS-1:0]      adc_analog_en_o,
   output logic                     debug_port_en_o,
   output logic                     slow_rc_clock_out_o
);

   pfr_state_t st;
   pfr_state_t next_st;

   //==============================================================
   // next state
   always_comb
   begin
      logic val;
      logic en;
      logic od;
      logic pull;
      logic sys_rst;
      logic tck_debug;
      logic [7:0] fmask;
      val       = 1'b0;
      en        = 1'b0;
      od        = 1'b0;
      pull      = 1'b0;
      sys_rst   = 1'b0;
      tck_debug = 1'b0;
      fmask     = 8'h00;
      next_st   = st;

      // three-stage synchronisers
      next_st.rst_pin_sync   = {st.rst_pin_sync[1:0], ext_reset_pin_n_i};
      next_st.rst_pin_stable = sync_stable(st.rst_pin_sync[1], st.rst_pin_sync[2], st.rst_pin_stable);
      next_st.tck_sync       = {st.tck_sync[1:0], port_a_line_zero_in_i};
      next_st.tck_stable     = sync_stable(st.tck_sync[1], st.tck_sync[2], st.tck_stable);
      next_st.rc_sync        = {st.rc_sync[1:0], slow_rc_oscillator_i};
      next_st.rc_stable      = sync_stable(st.rc_sync[1], st.rc_sync[2], st.rc_stable);
      // pin and tck stages start at their pulled-up idle level, no x at release
      if (reset_i)
      begin
         next_st.rst_pin_sync   = 3'b111;
         next_st.rst_pin_stable = 1'b1;
         next_st.tck_sync       = 3'b111;
         next_st.tck_stable     = 1'b1;
      end
      sys_rst          = reset_i | ~next_st.rst_pin_stable;
      next_st.in_reset = sys_rst;

      // debug port decision at reset release
      if (sys_rst)
         next_st.debug_en = 1'b0;
      else if (st.in_reset)
         next_st.debug_en = ~next_st.tck_stable;                 // see RULE1
      else
         next_st.debug_en = st.debug_en;                         // see RULE20

      // pad configuration
      for (int i = 0; i < NUM_PADS; i++)
      begin
         if (sys_rst)
            next_st.cfg[i] = pad_reset_cfg(i);                   // see RULE8 see RULE10 see RULE11
         else if (cfg_wr_i[i])
            next_st.cfg[i] = cfg_data_i;                         // see RULE9
      end

      // slow rc clock output, one-way disable
      if (reset_i)
         next_st.rc_en = 1'b1;                                   // see RULE12
      else if (!st.in_reset && (next_st.cfg[RC_PAD].gpio_en || next_st.cfg[RC_PAD].func != FUNC_F
                                || !force_slow_clock_out_bit_i))
         next_st.rc_en = 1'b0;                                   // see RULE13
      else
         next_st.rc_en = st.rc_en;                               // see RULE14

      // per-pad drive, lowest precedence first
      tck_debug = sp_link_en_i & sp_two_pin_mode_i;
      for (int i = 0; i < NUM_PADS; i++)
      begin
         pull = next_st.cfg[i].pull;
         od   = 1'b0;
         if (next_st.cfg[i].gpio_en)
         begin
            val = next_st.cfg[i].out;
            en  = next_st.cfg[i].oe;
         end
         else if (i == RC_PAD && next_st.cfg[i].func == FUNC_F)
         begin
            val = next_st.rc_stable;
            en  = next_st.rc_en;                                 // see RULE12
         end
         else
         begin
            val = periph_out_i[i];
            en  = periph_oe_i[i];
            fmask = twi_func_mask(i);
            od    = TWI_PAD_MASK[i] & fmask[next_st.cfg[i].func]; // see RULE7
         end
         if (trace_oe_i[i])
         begin
            val = trace_out_i[i];                                // see RULE17
            en  = 1'b1;
            od  = 1'b0;
         end
         if (i == TCK_PAD && tck_debug)
         begin
            val = debug_data_out_pad_i;                          // see RULE19
            en  = 1'b1;
            od  = 1'b0;
         end
         if (next_st.debug_en && i <= TDI_PAD)                   // see RULE18 see RULE4
         begin
            od   = 1'b0;
            val  = (i == TDO_PAD) ? jtag_tdo_i : 1'b0;
            en   = (i == TDO_PAD);
            pull = (i != TDO_PAD);                               // see RULE2
         end
         if (i == RC_PAD && alt_crystal_out_pin_en_i)
         begin
            en   = 1'b0;                                         // see RULE17
            od   = 1'b0;
            pull = 1'b0;
         end
         if (i == TCK_PAD && sys_rst)
            pull = 1'b1;                                         // see RULE3
         next_st.od[i]       = od;
         next_st.pad_oe_n[i] = ~(en & (~od | ~val));             // see RULE7
         next_st.pad_out[i]  = val & ~od;
         next_st.pad_pull[i] = pull;
         next_st.adc_en[i]   = adc_req_i[i] & ADC_PAD_MASK[i] & ~(en & (~od | ~val)); // see RULE16
      end
   end

   //==============================================================
   // state register
   always_ff @(posedge clk_sys_i)
   begin
      st <= next_st;
   end

   assign pad_out_o           = st.pad_out;
   assign pad_oe_n_o          = st.pad_oe_n;
   assign pad_pull_o          = st.pad_pull;
   assign adc_analog_en_o     = st.adc_en;
   assign debug_port_en_o     = st.debug_en;
   assign slow_rc_clock_out_o = st.rc_en;

   //==============================================================
   // checks
   property p_debug_latch;
      @(posedge clk_sys_i) disable iff (reset_i)
      $fell(st.in_reset) |-> (st.debug_en == ~st.tck_stable);
   endproperty
   a_debug_latch: assert property (p_debug_latch) else $error("debug enable not taken from tck at release"); // see RULE1

   property p_debug_hold;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!st.in_reset && $past(st.in_reset) == 1'b0) |-> $stable(st.debug_en);
   endproperty
   a_debug_hold: assert property (p_debug_hold) else $error("debug enable changed outside reset"); // see RULE20

   property p_tck_pull_reset;
      @(posedge clk_sys_i) disable iff (reset_i)
      st.in_reset |-> pad_pull_o[TCK_PAD];
   endproperty
   a_tck_pull_reset: assert property (p_tck_pull_reset) else $error("tck pull-up off during reset"); // see RULE3

   property p_debug_pads;
      @(posedge clk_sys_i) disable iff (reset_i)
      st.debug_en |-> (pad_pull_o[TCK_PAD] && pad_pull_o[TMS_PAD] && pad_pull_o[TDI_PAD]
                       && !pad_pull_o[TDO_PAD] && !pad_oe_n_o[TDO_PAD] && pad_oe_n_o[TMS_PAD]);
   endproperty
   a_debug_pads: assert property (p_debug_pads) else $error("debug port pads wrong"); // see RULE2

   property p_rc_never_back;
      @(posedge clk_sys_i) disable iff (reset_i)
      !st.rc_en |=> !st.rc_en [*3];
   endproperty
   a_rc_never_back: assert property (p_rc_never_back) else $error("slow clock output came back"); // see RULE14

   property p_rc_force_off;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!st.in_reset && !force_slow_clock_out_bit_i) |=> !st.rc_en;
   endproperty
   a_rc_force_off: assert property (p_rc_force_off) else $error("force bit zero did not stop clock"); // see RULE13

   property p_open_drain;
      @(posedge clk_sys_i) disable iff (reset_i)
      (st.od & ~pad_oe_n_o) == '0 || (st.od & pad_out_o) == '0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open-drain pad driven high"); // see RULE7

   property p_adc_blocked;
      @(posedge clk_sys_i) disable iff (reset_i)
      (adc_analog_en_o & ~pad_oe_n_o & ~st.od) == '0;
   endproperty
   a_adc_blocked: assert property (p_adc_blocked) else $error("analog input on driven pad"); // see RULE16

   property p_rc_reset_default;
      @(posedge clk_sys_i) disable iff (reset_i)
      $fell(st.in_reset) |-> (st.cfg[RC_PAD].func == FUNC_F && !st.cfg[RC_PAD].gpio_en
                              && st.cfg[5].func == FUNC_B && !st.cfg[5].gpio_en);
   endproperty
   a_rc_reset_default: assert property (p_rc_reset_default) else $error("reset defaults not applied"); // see RULE11

endmodule : pfr_pad_function

/* File: testbench/pfr_board_model.sv */
//==============================================================
// Purpose : board circuitry and debug probe seen from the pads
// Assumes : reset pin has a permanent pull-up
// Notes   : an undriven tck line without pull shows the inverse of its last value
//==============================================================
`timescale 1ns/1ps

module pfr_board_model
(
   // requests from the bench
   input  wire logic pin_low_i,
   input  wire logic probe_tck_low_i,
   // tck pad as driven by the device
   input  wire logic tck_oe_n_i,
   input  wire logic tck_out_i,
   input  wire logic tck_pull_i,
   // board side lines
   output logic      reset_pin_n_o,
   output logic      tck_level_o,
   output logic      rc_osc_o
);
   //==============================================================
   // lines
   initial
   begin
      rc_osc_o = 1'h0;
      forever #15625 rc_osc_o = ~rc_osc_o;
   end
   // board never drives the pin high, only the pull-up does
   assign reset_pin_n_o = ~pin_low_i;
   initial
   begin
      tck_level_o = 1'h1;
      forever
      begin
         @(probe_tck_low_i or tck_oe_n_i or tck_out_i or tck_pull_i);
         if (probe_tck_low_i)
            tck_level_o = 1'h0;
         else if (!tck_oe_n_i)
            tck_level_o = tck_out_i;
         else if (tck_pull_i)
            tck_level_o = 1'h1;
         else
            tck_level_o = ~tck_level_o;
      end
   end
endmodule : pfr_board_model

/* File: testbench/pfr_pad_function_tb.sv */
//==============================================================
// Purpose : self-checking bench for the pad function block
// Assumes : inputs change on the falling edge
// Notes   : run is cut short at 5000 cycles
//==============================================================
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
   $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end

module pfr_pad_function_tb;
   import pfr_pkg::*;
   logic                clk = 1'h0, rst = 1'h1, pin_low = 1'h0, probe_low = 1'h0, frc = 1'h1;
   logic                tdo = 1'h0, sp_en = 1'h0, sp_two = 1'h0, dout = 1'h0, xen = 1'h0;
   logic [NUM_PADS-1:0] wr = '0, pout = '0, poe = '0, tout = '0, toe = '0, adc = '0;
   pfr_pad_cfg_t        cd = '0;
   logic                pin_n, tck, rc, dbg, slow;
   logic [NUM_PADS-1:0] pad_out, oe_n, pull, adc_en;
   int                  failures = 0, checks = 0, cyc = 0;

   //==============================================================
   // clock, timeout, instances
   initial forever #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         print_verdict();
      end
   end
   pfr_board_model BRD (.pin_low_i(pin_low), .probe_tck_low_i(probe_low), .tck_oe_n_i(oe_n[0]),
      .tck_out_i(pad_out[0]), .tck_pull_i(pull[0]), .reset_pin_n_o(pin_n), .tck_level_o(tck), .rc_osc_o(rc));
   pfr_pad_function DUT (.clk_sys_i(clk), .reset_i(rst), .ext_reset_pin_n_i(pin_n), .cfg_wr_i(wr),
      .cfg_data_i(cd), .force_slow_clock_out_bit_i(frc), .periph_out_i(pout), .periph_oe_i(poe),
      .trace_out_i(tout), .trace_oe_i(toe), .jtag_tdo_i(tdo), .sp_link_en_i(sp_en),
      .sp_two_pin_mode_i(sp_two), .debug_data_out_pad_i(dout), .alt_crystal_out_pin_en_i(xen),
      .slow_rc_oscillator_i(rc), .adc_req_i(adc), .port_a_line_zero_in_i(tck), .pad_out_o(pad_out),
      .pad_oe_n_o(oe_n), .pad_pull_o(pull), .adc_analog_en_o(adc_en), .debug_port_en_o(dbg),
      .slow_rc_clock_out_o(slow));

   //==============================================================
   // tasks
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic wcfg(input int idx, input pfr_pad_cfg_t c);
      wr[idx] = 1'h1;
      cd = c;
      tick(1);
      wr = '0;
      tick(2);
   endtask : wcfg
   task automatic pwr_reset;
      rst = 1'h1;
      tick(4);
      rst = 1'h0;
      tick(3);
   endtask : pwr_reset
   task automatic pin_reset(input logic tck_low);
      probe_low = tck_low;
      pin_low = 1'h1;
      tick(8);
      `CHK(pull[0], 1'h1)
      pin_low = 1'h0;
      tick(8);
      probe_low = 1'h0;
      tick(2);
   endtask : pin_reset
   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   //==============================================================
   // tests
   initial
   begin
      tick(2);
      `CHK(dbg, 1'h0)
      `CHK(pull[0], 1'h1)
      `CHK(oe_n[RC_PAD], 1'h0)
      `CHK(slow, 1'h1)
      rst = 1'h0;
      tick(3);
      `CHK(pull, PULL_RESET_MASK)
      `CHK(oe_n, ~(36'h0_0000_0001 << RC_PAD))
      `CHK(dbg, 1'h0)
      poe = TWI_PAD_MASK;
      tick(2);
      `CHK(oe_n & TWI_PAD_MASK, 36'h0_0000_0000)
      pout = TWI_PAD_MASK;
      tick(2);
      `CHK(oe_n & TWI_PAD_MASK, TWI_PAD_MASK)
      `CHK(pad_out & TWI_PAD_MASK, 36'h0_0000_0000)
      wcfg(5, '{1'h1, 3'h0, 1'h1, 1'h1, 1'h0});
      `CHK({oe_n[5], pad_out[5]}, 2'h1)
      poe = '0;
      done("defaults");
      wcfg(4, '{1'h1, 3'h0, 1'h1, 1'h1, 1'h0});
      `CHK({oe_n[4], pad_out[4]}, 2'h1)
      wcfg(TCK_PAD, '{1'h1, 3'h0, 1'h1, 1'h1, 1'h1});
      `CHK({oe_n[0], pad_out[0]}, 2'h1)
      wcfg(9, '{1'h1, 3'h0, 1'h0, 1'h0, 1'h1});
      `CHK(pull, 36'h0_0000_0201)
      toe[9] = 1'h1;
      tout[9] = 1'h1;
      adc[14] = 1'h1;
      tick(2);
      `CHK({oe_n[9], pad_out[9]}, 2'h1)
      `CHK(adc_en[14], 1'h1)
      wcfg(14, '{1'h1, 3'h0, 1'h1, 1'h0, 1'h0});
      `CHK(adc_en[14], 1'h0)
      {toe[0], sp_en, sp_two, dout} = 4'hF;
      tick(2);
      `CHK({oe_n[0], pad_out[0]}, 2'h1)
      sp_two = 1'h0;
      tick(2);
      `CHK(pad_out[0], 1'h0)
      {toe, tout, sp_en, adc} = '0;
      done("mux");
      pin_reset(1'h1);
      `CHK(dbg, 1'h1)
      `CHK(pull[3:0], 4'hB)
      tdo = 1'h1;
      toe[1] = 1'h1;
      tick(2);
      `CHK(oe_n[3:0], 4'hB)
      `CHK(pad_out[2], 1'h1)
      `CHK(dbg, 1'h1)
      pin_reset(1'h0);
      `CHK(dbg, 1'h0)
      `CHK(oe_n[3:0], 4'hD)
      `CHK(pull[3:0], 4'h1)
      toe = '0;
      done("debug");
      for (int k = 0; k < 3; k++)
      begin
         pwr_reset();
         `CHK(slow, 1'h1)
         if (k == 0)
            wcfg(RC_PAD, '{1'h1, FUNC_F, 1'h0, 1'h0, 1'h0});
         else if (k == 1)
            wcfg(RC_PAD, '{1'h0, FUNC_C, 1'h0, 1'h0, 1'h0});
         else
         begin
            frc = 1'h0;
            tick(3);
            frc = 1'h1;
            tick(3);
         end
         `CHK({slow, oe_n[RC_PAD]}, 2'h1)
      end
      pin_reset(1'h0);
      `CHK(slow, 1'h0)
      xen = 1'h1;  // rc output already off
      tick(2);
      `CHK({oe_n[RC_PAD], pull[RC_PAD]}, 2'h2)
      done("slow clock");
      print_verdict();
   end
endmodule : pfr_pad_function_tb
